// ===== hdl/pip_top.sv
/*
 * Platform interrupt prioritizer: 52 level sources, per-source priority,
 * pending and enable bits, one threshold and a claim/complete port for a
 * single machine-mode hart, reached over Avalon-MM with waitrequest.
 * Assumes sources may come from another domain (synchronised here) and
 * that the bus master holds each request until waitrequest is low.
 */
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/10ps

// Operation
// - Take 52 source inputs with seven nonzero priority levels.
// - Every register is one aligned 32-bit word.
// - Sources are sampled as active-high levels, not edges.
// - ID zero names no source and means no interrupt.
// - IDs: 1 watchdog, 2 clock, 3-4 UARTs, 5-7 SPI, 8-39 GPIO, 40-51 PWM, 52 I2C.
// - Priority word at base plus four times ID, bits 2:0, rest zero.
// - A source with priority zero is never presented.
// - Priority one is lowest active, seven is highest.
// - Equal priorities resolve to the smallest ID.
// - Pending reads as two words, bit N mod 32 of word N/32.
// - Pending bit zero of the low word reads zero.
// - Pending clears only by enabling the source and claiming it.
// - Pending words read-only, reset zero, high word bits 31:21 zero.
// - Enable words sit at the two consecutive enable offsets, read-write.
// - Threshold and claim/complete sit at consecutive offsets, read-write.
// - One enable bit per source, packed like pending, bit zero fixed zero.
// - Priorities at or below the threshold are masked from the hart.
// - Claim read returns best enabled pending ID or zero, clears it, ignores threshold.
// - Completion writes the ID; unchecked against claim; ignored if not enabled.
module pip_top
(
    input wire logic i_clk,                          // Core clock, 250 MHz
    input wire logic i_srst,                         // Synchronous reset, high
    input wire logic [pip_pkg::NSRC:1] i_src,        // Bit N is source ID N
    input wire pip_pkg::pip_avs_req_t i_avs_req,     // Avalon-MM request
    output pip_pkg::pip_avs_rsp_t o_avs_rsp,         // Avalon-MM answer
    output logic o_ext_irq                           // External interrupt to hart
);

    // ----------------------------------------------------------------------
    // State
    // ----------------------------------------------------------------------
    logic [pip_pkg::NSRC:1] src_meta_q;
    logic [pip_pkg::NSRC:1] src_sync_q;
    logic [pip_pkg::NSRC:1] pend_q;
    logic [pip_pkg::NSRC:1] insvc_q;
    logic [pip_pkg::NSRC:1] en_q;
    logic [pip_pkg::PRIO_W-1:0] prio_q [pip_pkg::NSRC:1];
    logic [pip_pkg::PRIO_W-1:0] thr_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic irq_q;

    // ----------------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------------
    // One access is acted on at the edge where it is first seen
    wire logic req = i_avs_req.read | i_avs_req.write;
    wire logic act = req & ~ack_q;
    wire logic [31:0] addr = i_avs_req.address;
    wire logic [31:0] wdata = i_avs_req.writedata;
    wire logic aligned = (addr[1:0] == 2'h0);
    wire logic full_word = (i_avs_req.byteenable == 4'hF);
    wire logic prio_hit = aligned && addr >= pip_pkg::PRIO_FIRST
                          && addr <= pip_pkg::PRIO_LAST;
    wire logic [pip_pkg::ID_W-1:0] prio_idx = addr[pip_pkg::ID_W+1:2];
    wire logic pend_lo_hit = (addr == pip_pkg::PEND_LO_ADDR);
    wire logic pend_hi_hit = (addr == pip_pkg::PEND_HI_ADDR);
    wire logic en_lo_hit = (addr == pip_pkg::EN_LO_ADDR);
    wire logic en_hi_hit = (addr == pip_pkg::EN_HI_ADDR);
    wire logic thr_hit = (addr == pip_pkg::THRESH_ADDR);
    wire logic claim_hit = (addr == pip_pkg::CLAIM_ADDR);
    wire logic wr_ok = act & i_avs_req.write & full_word;
    wire logic claim_go = act & i_avs_req.read & claim_hit;
    wire logic cmp_go = wr_ok & claim_hit;

    // Packed views: bit 0 stands for absent source 0, top bits reserved
    wire logic [63:0] pend_vec = {11'h000, pend_q, 1'b0};
    wire logic [63:0] en_vec = {11'h000, en_q, 1'b0};

    // ----------------------------------------------------------------------
    // Selection
    // ----------------------------------------------------------------------
    logic [pip_pkg::ID_W-1:0] best_id;
    logic [pip_pkg::PRIO_W-1:0] best_prio;

    // Ascending scan, strictly greater: zero never wins, lowest ID wins ties
    always_comb
    begin
        best_id = '0;
        best_prio = '0;
        for (int i = 1; i <= int'(pip_pkg::NSRC); i++)
        begin
            if (pend_q[i] && en_q[i] && prio_q[i] > best_prio)
            begin
                best_prio = prio_q[i];
                best_id = pip_pkg::ID_W'(i);
            end
        end
    end

    // Completion ID must name a real, currently enabled source
    wire logic [pip_pkg::ID_W-1:0] cmp_id = wdata[pip_pkg::ID_W-1:0];
    wire logic cmp_valid = cmp_go && (wdata[31:pip_pkg::ID_W] == '0)
                           && en_vec[cmp_id];

    // Per-source claim and completion strobes
    logic [pip_pkg::NSRC:1] claim_vec;
    logic [pip_pkg::NSRC:1] cmp_vec;

    always_comb
    begin
        for (int i = 1; i <= int'(pip_pkg::NSRC); i++)
        begin
            claim_vec[i] = claim_go && (best_id == pip_pkg::ID_W'(i));
            cmp_vec[i] = cmp_valid && (cmp_id == pip_pkg::ID_W'(i));
        end
    end

    // Read data multiplexer; unmapped addresses read zero
    wire logic [31:0] rd_mux =
        prio_hit ? {29'h0, prio_q[prio_idx]} :
        pend_lo_hit ? pend_vec[31:0] :
        pend_hi_hit ? pend_vec[63:32] :
        en_lo_hit ? en_vec[31:0] :
        en_hi_hit ? en_vec[63:32] :
        thr_hit ? {29'h0, thr_q} :
        claim_hit ? {26'h0, best_id} :
        32'h0000_0000;

    // ----------------------------------------------------------------------
    // Source synchroniser
    // ----------------------------------------------------------------------
    // Two stages before any logic sees a source level
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            src_meta_q <= '0;
            src_sync_q <= '0;
        end
        else
        begin
            src_meta_q <= i_src;
            src_sync_q <= src_meta_q;
        end
    end

    // ----------------------------------------------------------------------
    // Gateways and pending bits
    // ----------------------------------------------------------------------
    // Level sets pending unless in service; claim clears and marks in service
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            pend_q <= '0;
            insvc_q <= '0;
        end
        else
        begin
            pend_q <= ~claim_vec & (pend_q | (src_sync_q & ~insvc_q));
            insvc_q <= claim_vec | (insvc_q & ~cmp_vec);
        end
    end

    // ----------------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------------
    // Priorities, enables and threshold; partial-word writes are ignored
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            for (int i = 1; i <= int'(pip_pkg::NSRC); i++)
            begin
                prio_q[i] <= pip_pkg::PRIO_RST;
            end
            en_q <= {pip_pkg::NSRC{pip_pkg::EN_RST}};
            thr_q <= pip_pkg::THR_RST;
        end
        else
        begin
            if (wr_ok && prio_hit)
            begin
                prio_q[prio_idx] <= wdata[pip_pkg::PRIO_W-1:0];
            end
            if (wr_ok && en_lo_hit)
            begin
                en_q[31:1] <= wdata[31:1];
            end
            if (wr_ok && en_hi_hit)
            begin
                en_q[pip_pkg::NSRC:32] <= wdata[pip_pkg::HI_BITS-1:0];
            end
            if (wr_ok && thr_hit)
            begin
                thr_q <= wdata[pip_pkg::PRIO_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------------
    // Bus answer and hart request
    // ----------------------------------------------------------------------
    // Answer one cycle after the request is seen; read data captured then
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            ack_q <= 1'b0;
            rdata_q <= pip_pkg::RDATA_RST;
            irq_q <= 1'b0;
        end
        else
        begin
            ack_q <= act;
            if (act && i_avs_req.read)
            begin
                rdata_q <= rd_mux;
            end
            irq_q <= (best_prio > thr_q);
        end
    end

    assign o_avs_rsp.readdata = rdata_q;
    assign o_avs_rsp.waitrequest = act;
    assign o_ext_irq = irq_q;

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    // Helper: some eligible source beats or ties the chosen one unfairly
    logic sel_wrong;

    always_comb
    begin
        sel_wrong = 1'b0;
        for (int i = 1; i <= int'(pip_pkg::NSRC); i++)
        begin
            if (pend_q[i] && en_q[i] && prio_q[i] != '0)
            begin
                if (prio_q[i] > best_prio)
                begin
                    sel_wrong = 1'b1;
                end
                if (prio_q[i] == best_prio && pip_pkg::ID_W'(i) < best_id)
                begin
                    sel_wrong = 1'b1;
                end
            end
        end
    end

    a_select_best_source: assert property (claim_go |-> !sel_wrong)
        else $error("claim did not pick highest priority, lowest ID");

    a_zero_prio_hidden: assert property ((best_id != '0) |-> (best_prio != '0))
        else $error("source with priority zero was selected");

    a_claim_clears_pend: assert property (
        (claim_go && best_id != '0) |=> !pend_vec[$past(best_id)]
                                         && insvc_q[$past(best_id)])
        else $error("claimed source still pending or not in service");

    a_claim_read_id: assert property (
        claim_go |=> !o_avs_rsp.waitrequest && rdata_q == {26'h0, $past(best_id)})
        else $error("claim read returned wrong ID");

    a_hold_until_done: assert property (
        (insvc_q[52] && !cmp_vec[52]) |=> !pend_q[52] && insvc_q[52])
        else $error("in-service source became pending before completion");

    a_irq_over_thresh: assert property (
        (best_prio > thr_q) ##1 (best_prio > thr_q) |-> o_ext_irq)
        else $error("request low though eligible priority exceeds threshold");

    a_irq_masked: assert property (
        (thr_q == 3'h7) ##1 (thr_q == 3'h7) |-> !o_ext_irq)
        else $error("request raised with threshold at seven");

    a_pend_reserved: assert property (
        (act && i_avs_req.read && (pend_hi_hit || pend_lo_hit))
        |=> rdata_q[0] == ($past(pend_hi_hit) & $past(pend_q[32]))
            && (!$past(pend_hi_hit) || rdata_q[31:21] == '0))
        else $error("pending readback reserved bits not zero");

    // Helper: last priority write seen, kept apart from the register array
    logic [pip_pkg::ID_W-1:0] chk_idx_q;
    logic [pip_pkg::PRIO_W-1:0] chk_val_q;
    logic chk_seen_q;

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            chk_idx_q <= '0;
            chk_val_q <= '0;
            chk_seen_q <= 1'b0;
        end
        else if (wr_ok && prio_hit)
        begin
            chk_idx_q <= prio_idx;
            chk_val_q <= wdata[pip_pkg::PRIO_W-1:0];
            chk_seen_q <= 1'b1;
        end
    end

    a_prio_readback: assert property (
        (act && i_avs_req.read && prio_hit && chk_seen_q && prio_idx == chk_idx_q)
        |=> rdata_q == {29'h0, $past(chk_val_q)})
        else $error("priority word did not read back its low three bits");

    a_pend_needs_level: assert property (
        1'b1 |=> (pend_q & ~$past(pend_q) & ~$past(src_sync_q)) == '0)
        else $error("pending bit set without a high source level");

    a_pend_falls_claim: assert property (
        1'b1 |=> (~pend_q & $past(pend_q) & ~$past(claim_vec)) == '0)
        else $error("pending bit cleared without a claim");

    a_cmp_needs_enable: assert property (
        (cmp_go && !cmp_valid) |=> insvc_q == $past(insvc_q))
        else $error("ignored completion changed service state");

    a_partial_dropped: assert property (
        (act && i_avs_req.write && !full_word)
        |=> en_q == $past(en_q) && thr_q == $past(thr_q))
        else $error("partial-word write changed a register");

    a_claim_empty_zero: assert property (
        (claim_go && best_prio == '0) |=> rdata_q == 32'h0000_0000)
        else $error("claim with nothing eligible did not read zero");

    a_answer_one_cycle: assert property (
        act |=> !o_avs_rsp.waitrequest ##1 (!req || o_avs_rsp.waitrequest))
        else $error("bus answer not given one cycle after request");

endmodule

// ===== inc/pip_pkg.sv
/*
 * Shared constants and carrier types for the platform interrupt prioritizer:
 * register byte addresses, field widths, reset values and the bus structs.
 * Assumes a 32-bit Avalon-MM byte address and one machine-mode hart target.
 */
package pip_pkg;

    // ----------------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------------
    localparam int unsigned NSRC = 52;       // Real sources, IDs 1..52
    localparam int unsigned PRIO_W = 3;      // Priority and threshold width
    localparam int unsigned ID_W = 6;        // Width of a source ID
    localparam int unsigned HI_BITS = 21;    // Used bits of the high words
    localparam int unsigned WORD_W = 32;     // Bus data width

    // ----------------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------------
    localparam logic [31:0] PRIO_BASE = 32'h0C00_0000;  // Slot of absent source 0
    localparam logic [31:0] PRIO_FIRST = 32'h0C00_0004; // Source 1 priority
    localparam logic [31:0] PRIO_LAST = 32'h0C00_00D0;  // Source 52 priority
    localparam logic [31:0] PEND_LO_ADDR = 32'h0C00_1000;
    localparam logic [31:0] PEND_HI_ADDR = 32'h0C00_1004;
    localparam logic [31:0] EN_LO_ADDR = 32'h0C00_2000;
    localparam logic [31:0] EN_HI_ADDR = 32'h0C00_2004;
    localparam logic [31:0] THRESH_ADDR = 32'h0C20_0000;
    localparam logic [31:0] CLAIM_ADDR = 32'h0C20_0004;

    // ----------------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------------
    localparam logic [2:0] PRIO_RST = 3'h0;
    localparam logic [2:0] THR_RST = 3'h0;
    localparam logic EN_RST = 1'b0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // ----------------------------------------------------------------------
    // Bus carriers
    // ----------------------------------------------------------------------
    typedef struct packed {
        logic read;
        logic write;
        logic [31:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } pip_avs_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } pip_avs_rsp_t;

endpackage

// ===== sim/pip_hart_model.sv
/*
 * Behavioural model of the machine-mode hart as an Avalon-MM master.
 * Assumes the bench calls xfer one access at a time from one process.
 */
`timescale 1ns/10ps

module pip_hart_model
(
    input wire logic i_clk,                       // Core clock
    input wire pip_pkg::pip_avs_rsp_t i_avs_rsp,  // Slave answer
    output pip_pkg::pip_avs_req_t o_avs_req       // Master request
);
    // ----------------------------------------------------------------------
    // Bus master
    // ----------------------------------------------------------------------
    // Byte lanes of the next access; the bench narrows it to try a partial write
    logic [3:0] be_sel = 4'hF;

    // Idle bus at time zero
    initial o_avs_req = '0;

    // One aligned word access; held until waitrequest is seen low, however long
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] data,
                        output logic [31:0] rdata);
        @(posedge i_clk);
        o_avs_req.read <= ~wr;
        o_avs_req.write <= wr;
        o_avs_req.address <= {addr[31:2], 2'b00};
        o_avs_req.writedata <= data;
        o_avs_req.byteenable <= be_sel;
        do
        begin
            @(posedge i_clk);
        end
        while (i_avs_rsp.waitrequest !== 1'b0);
        rdata = i_avs_rsp.readdata;
        // Released lines show a changed pattern, not the last value
        o_avs_req.read <= 1'b0;
        o_avs_req.write <= 1'b0;
        o_avs_req.address <= ~addr;
        o_avs_req.writedata <= ~data;
    endtask
endmodule

// ===== sim/test_platform_interrupt_prioritizer.sv
/*
 * Self-checking bench for the interrupt prioritizer: registers, pending,
 * priority selection, threshold, claim and completion.
 * Assumes pip_top, pip_pkg and the hart model are compiled first.
 */
`timescale 1ns/10ps

module test_platform_interrupt_prioritizer;
    logic i_clk;
    logic i_srst;
    logic [pip_pkg::NSRC:1] src;
    pip_pkg::pip_avs_req_t avs_req;
    pip_pkg::pip_avs_rsp_t avs_rsp;
    logic ext_irq;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;

    pip_top DUT (.i_clk(i_clk), .i_srst(i_srst), .i_src(src), .i_avs_req(avs_req),
                 .o_avs_rsp(avs_rsp), .o_ext_irq(ext_irq));
    pip_hart_model hart (.i_clk(i_clk), .i_avs_rsp(avs_rsp), .o_avs_req(avs_req));

    // ----------------------------------------------------------------------
    // Clock, timeout and helpers
    // ----------------------------------------------------------------------
    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    // Cuts a hang short
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (miscompares == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e, input string what);
        logic [31:0] q;
        hart.xfer(1'b0, a, 32'h0000_0000, q);
        check(what, q, e);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        hart.xfer(1'b1, a, d, q);
    endtask

    // Source to request path is about four cycles
    task automatic settle();
        repeat (6) @(posedge i_clk);
    endtask

    function automatic logic [31:0] pa(input int id);
        return pip_pkg::PRIO_BASE + 32'(4 * id);
    endfunction

    // ----------------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------------
    // Reset values and unmapped holes
    task automatic t_reset();
        rd(pa(1), 32'h0000_0000, "prio1");
        rd(pa(52), 32'h0000_0000, "prio52");
        rd(pip_pkg::PEND_LO_ADDR, 32'h0000_0000, "pend_lo");
        rd(pip_pkg::PEND_HI_ADDR, 32'h0000_0000, "pend_hi");
        rd(pip_pkg::CLAIM_ADDR, 32'h0000_0000, "claim_none");
        wr(pip_pkg::PRIO_BASE, 32'h0000_0007);
        rd(pip_pkg::PRIO_BASE, 32'h0000_0000, "prio0");
        rd(32'h0C00_00D4, 32'h0000_0000, "hole");
        check("irq_rst", {31'h0, ext_irq}, 32'h0000_0000);
    endtask

    // Field widths of the writable words
    task automatic t_fields();
        wr(pa(5), 32'hFFFF_FFFF);
        rd(pa(5), 32'h0000_0007, "prio5");
        wr(pip_pkg::EN_LO_ADDR, 32'hFFFF_FFFF);
        rd(pip_pkg::EN_LO_ADDR, 32'hFFFF_FFFE, "en_lo");
        wr(pip_pkg::EN_HI_ADDR, 32'hFFFF_FFFF);
        rd(pip_pkg::EN_HI_ADDR, 32'h001F_FFFF, "en_hi");
        wr(pip_pkg::THRESH_ADDR, 32'hFFFF_FFFF);
        rd(pip_pkg::THRESH_ADDR, 32'h0000_0007, "thr");
    endtask

    // Levels reach the pending words; priority zero is never served
    task automatic t_pending();
        @(posedge i_clk);
        src[1] <= 1'b1;
        src[31] <= 1'b1;
        src[32] <= 1'b1;
        src[52] <= 1'b1;
        settle();
        rd(pip_pkg::PEND_LO_ADDR, 32'h8000_0002, "pend_lo_set");
        rd(pip_pkg::PEND_HI_ADDR, 32'h0010_0001, "pend_hi_set");
        wr(pip_pkg::PEND_HI_ADDR, 32'h0000_0000);
        rd(pip_pkg::PEND_HI_ADDR, 32'h0010_0001, "pend_ro");
        rd(pip_pkg::CLAIM_ADDR, 32'h0000_0000, "claim_prio0");
    endtask

    // Ranking, ties, threshold and claim
    task automatic t_select();
        wr(pa(1), 32'h0000_0001);
        wr(pa(31), 32'h0000_0003);
        wr(pa(32), 32'h0000_0003);
        wr(pa(52), 32'h0000_0007);
        settle();
        check("irq_thr7", {31'h0, ext_irq}, 32'h0000_0000);
        rd(pip_pkg::CLAIM_ADDR, 32'd52, "claim52");
        settle();
        rd(pip_pkg::PEND_HI_ADDR, 32'h0000_0001, "pend_claimed");
        wr(pip_pkg::THRESH_ADDR, 32'h0000_0003);
        settle();
        check("irq_thr3", {31'h0, ext_irq}, 32'h0000_0000);
        wr(pip_pkg::THRESH_ADDR, 32'h0000_0002);
        settle();
        check("irq_thr2", {31'h0, ext_irq}, 32'h0000_0001);
        rd(pip_pkg::CLAIM_ADDR, 32'd31, "claim31");
        rd(pip_pkg::CLAIM_ADDR, 32'd32, "claim32");
        rd(pip_pkg::CLAIM_ADDR, 32'd1, "claim1");
        rd(pip_pkg::CLAIM_ADDR, 32'd0, "claim_empty");
        rd(pip_pkg::PEND_LO_ADDR, 32'h0000_0000, "pend_lo_clr");
        settle();
        check("irq_none", {31'h0, ext_irq}, 32'h0000_0000);
    endtask

    // Completion gated by enable, unchecked against the last claim
    task automatic t_complete();
        wr(pip_pkg::EN_HI_ADDR, 32'h0000_0000);
        wr(pip_pkg::CLAIM_ADDR, 32'd52);
        wr(pip_pkg::EN_HI_ADDR, 32'h001F_FFFF);
        settle();
        rd(pip_pkg::PEND_HI_ADDR, 32'h0000_0000, "cmpl_disabled");
        wr(pip_pkg::CLAIM_ADDR, 32'd52);
        settle();
        rd(pip_pkg::PEND_HI_ADDR, 32'h0010_0000, "cmpl_repend");
        check("irq_repend", {31'h0, ext_irq}, 32'h0000_0001);
        wr(pip_pkg::CLAIM_ADDR, 32'd31);
        settle();
        rd(pip_pkg::PEND_LO_ADDR, 32'h8000_0000, "cmpl_older");
    endtask

    // A write with only one byte lane is dropped
    task automatic t_partial();
        hart.be_sel = 4'h1;
        wr(pip_pkg::THRESH_ADDR, 32'h0000_0005);
        hart.be_sel = 4'hF;
        rd(pip_pkg::THRESH_ADDR, 32'h0000_0002, "thr_partial");
    endtask

    // Reset in mid-run, with the bus idle, clears every register
    task automatic t_reset_again();
        @(posedge i_clk);
        src <= '0;
        i_srst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        rd(pa(52), 32'h0000_0000, "prio52_rst");
        rd(pip_pkg::EN_LO_ADDR, 32'h0000_0000, "en_lo_rst");
        rd(pip_pkg::EN_HI_ADDR, 32'h0000_0000, "en_hi_rst");
        rd(pip_pkg::THRESH_ADDR, 32'h0000_0000, "thr_rst");
        rd(pip_pkg::PEND_HI_ADDR, 32'h0000_0000, "pend_hi_rst");
        check("irq_rst2", {31'h0, ext_irq}, 32'h0000_0000);
    endtask

    // First GPIO pin and first PWM channel claim under their own IDs
    task automatic t_map();
        wr(pa(8), 32'h0000_0001);
        wr(pa(40), 32'h0000_0001);
        wr(pip_pkg::EN_LO_ADDR, 32'h0000_0100);
        wr(pip_pkg::EN_HI_ADDR, 32'h0000_0100);
        @(posedge i_clk);
        src[8] <= 1'b1;
        src[40] <= 1'b1;
        settle();
        check("irq_map", {31'h0, ext_irq}, 32'h0000_0001);
        rd(pip_pkg::CLAIM_ADDR, 32'd8, "claim_gpio");
        rd(pip_pkg::CLAIM_ADDR, 32'd40, "claim_pwm");
    endtask

    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    initial
    begin
        i_srst = 1'b1;
        src = '0;
        repeat (3) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        t_reset();
        t_fields();
        t_pending();
        t_select();
        t_complete();
        t_partial();
        t_reset_again();
        t_map();
        report_and_stop();
    end
endmodule
